// ===== rtl/sfsu_defs.svh
`ifndef SFSU_DEFS_SVH
`define SFSU_DEFS_SVH

// Instruction words of the flag-set and shift group
`define SFSU_OPC_SET_CLAMP   16'h0058
`define SFSU_OPC_SET_CARRY   16'h0018
`define SFSU_MSK_FIXED       16'hffff
// Dynamic forms match on top nibble and low nibble only
`define SFSU_MSK_DYN         16'hf00f
`define SFSU_OPC_DYN_ARITH   16'h400c
`define SFSU_OPC_DYN_LOGIC   16'h400d
// Single-register forms match on top nibble and low byte
`define SFSU_MSK_ONE         16'hf0ff
`define SFSU_OPC_ASL1        16'h4020
`define SFSU_OPC_ASR1        16'h4021
`define SFSU_OPC_LSL1        16'h4000
`define SFSU_OPC_LSL2        16'h4008
`define SFSU_OPC_LSL8        16'h4018
`define SFSU_OPC_LSL16       16'h4028
`define SFSU_OPC_LSR1        16'h4001
`define SFSU_OPC_LSR2        16'h4009
`define SFSU_OPC_LSR8        16'h4019
`define SFSU_OPC_LSR16       16'h4029

// Register index fields
`define SFSU_DEST_HI         11
`define SFSU_DEST_LO         8
`define SFSU_AMT_HI          7
`define SFSU_AMT_LO          4
// Size select of the fixed shifts
`define SFSU_FIX_HI 5
`define SFSU_FIX_LO 4
// Bit positions in the operands
`define SFSU_AMT_SIGN 31
`define SFSU_CNT_HI 4
`define SFSU_MSB 31
`define SFSU_LSB 0

// Shift amounts
`define SFSU_CNT_BITS        5
`define SFSU_SH_TWO          6'h02
`define SFSU_SH_EIGHT        6'h08
`define SFSU_SH_SIXTEEN      6'h10
`define SFSU_SH_ONE          6'h01
`define SFSU_SH_NONE 6'h00
// A negative amount with zero low bits asks for a full-width shift
`define SFSU_SH_FULL 6'h20

// Reset values of the flags
`define SFSU_CARRY_RST       1'b0
`define SFSU_CLAMP_RST       1'b0

`endif

// ===== rtl/sfsu_pkg.sv
package sfsu_pkg;

	typedef enum logic [3:0] {
		SFSU_OP_NONE  = 4'h0,
		SFSU_OP_CLAMP = 4'h1,
		SFSU_OP_CARRY = 4'h2,
		SFSU_OP_DYN_A = 4'h3,
		SFSU_OP_DYN_L = 4'h4,
		SFSU_OP_ASL1  = 4'h5,
		SFSU_OP_ASR1  = 4'h6,
		SFSU_OP_LSL1  = 4'h7,
		SFSU_OP_LSLN  = 4'h8,
		SFSU_OP_LSR1  = 4'h9,
		SFSU_OP_LSRN  = 4'ha
	} sfsu_op_t;

endpackage

// ===== rtl/sfsu_barrel.sv
`timescale 1ns/1ps
`default_nettype none
`include "sfsu_defs.svh"

module sfsu_barrel
	import sfsu_pkg::*;
(
	// Operand and shift request
	input wire logic [31:0] i_value,
	input wire logic [5:0] i_count,
	input wire logic i_right,
	input wire logic i_arith,
	// Result
	output logic [31:0] o_result
);

	logic [31:0] fill;
	logic [63:0] wide;

	always_comb begin
		fill = (i_arith && i_value[`SFSU_MSB]) ? 32'hffffffff : 32'h00000000;
		// Count of 32 is legal on the right; the 64-bit view keeps it defined
		wide = {fill, i_value} >> i_count;
		if (i_right) begin
			o_result = wide[31:0];
		end else begin
			o_result = i_value << i_count[`SFSU_CNT_HI:0];
		end
	end

endmodule // sfsu_barrel

`default_nettype wire

// ===== rtl/sfsu_core.sv
`timescale 1ns/1ps
`default_nettype none
`include "sfsu_defs.svh"

// Summary of operation
// - Clamp-flag opcode sets the clamp flag to one and raises hit, no write-back, one state.
// - Carry-set opcode forces carry to one in one state, registers untouched.
// - Dynamic arithmetic shift: left if amount non-negative, sign-filling right if negative.
// - Count is amount bits 4..0, negated when negative; left 0-31, right 1-32.
// - Dynamic logical shift: left if non-negative, zero-filling right if negative.
// - Arithmetic left by one, zero into bit 0, old top bit into carry.
// - Arithmetic right by one keeps sign, old bit 0 into carry.
// - Logical left by one behaves identically to arithmetic left by one.
// - Logical left by 2, 8, 16 discards bits, carry unchanged, one state.
// - Logical right by one, zero into top, old bit 0 into carry.
// - Logical right by 2, 8, 16 with zero fill, carry unchanged.

module sfsu_core
	import sfsu_pkg::*;
(
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	// Instruction from decode
	input wire logic i_valid,
	input wire logic [15:0] i_instr,
	// Operands read from the register file
	input wire logic [31:0] i_dest_reg,
	input wire logic [31:0] i_amount_reg,
	// Register file write-back
	output logic o_wr_en,
	output logic [3:0] o_wr_idx,
	output logic [31:0] o_wr_data,
	// Flags
	output logic o_carry,
	output logic o_clamp,
	output logic o_hit
);

	// Shifter request built from the decoded form
	sfsu_op_t op;
	logic [5:0] count;
	logic [5:0] dyn_count;
	logic [5:0] fix_count;
	logic shift_right;
	logic shift_arith;
	logic [31:0] shifted;
	logic [4:0] neg_low;
	logic amt_neg;

	logic wr_en_ff, nxt_wr_en;
	logic [3:0] wr_idx_ff, nxt_wr_idx;
	logic [31:0] wr_data_ff, nxt_wr_data;
	logic carry_ff, nxt_carry;
	logic clamp_ff, nxt_clamp;
	logic hit_ff, nxt_hit;

	// Decode
	always_comb begin
		op = SFSU_OP_NONE;
		if (i_valid) begin
			// Flag-set words carry no register fields and match whole
			if (i_instr == `SFSU_OPC_SET_CLAMP) begin
				op = SFSU_OP_CLAMP;
			end else if (i_instr == `SFSU_OPC_SET_CARRY) begin
				op = SFSU_OP_CARRY;
			end else if ((i_instr & `SFSU_MSK_DYN) == `SFSU_OPC_DYN_ARITH) begin
				op = SFSU_OP_DYN_A;
			end else if ((i_instr & `SFSU_MSK_DYN) == `SFSU_OPC_DYN_LOGIC) begin
				op = SFSU_OP_DYN_L;
			end else begin
				unique case (i_instr & `SFSU_MSK_ONE)
					`SFSU_OPC_ASL1: op = SFSU_OP_ASL1;
					`SFSU_OPC_LSL1: op = SFSU_OP_LSL1;
					`SFSU_OPC_ASR1: op = SFSU_OP_ASR1;
					`SFSU_OPC_LSR1: op = SFSU_OP_LSR1;
					`SFSU_OPC_LSL2, `SFSU_OPC_LSL8, `SFSU_OPC_LSL16: op = SFSU_OP_LSLN;
					`SFSU_OPC_LSR2, `SFSU_OPC_LSR8, `SFSU_OPC_LSR16: op = SFSU_OP_LSRN;
					// Rotates share this row but belong to a neighbouring unit
					default: op = SFSU_OP_NONE;
				endcase
			end
		end
	end

	// Dynamic count: negative amounts use the two's complement of the low bits
	always_comb begin
		// Sign of the whole register picks the direction, not bit 4
		amt_neg = i_amount_reg[`SFSU_AMT_SIGN];
		neg_low = 5'h00 - i_amount_reg[`SFSU_CNT_HI:0];
		if (!amt_neg) begin
			dyn_count = {1'b0, i_amount_reg[`SFSU_CNT_HI:0]};
		end else if (neg_low == 5'h00) begin
			// Low bits zero means a full 32-place right shift
			dyn_count = `SFSU_SH_FULL;
		end else begin
			dyn_count = {1'b0, neg_low};
		end
	end

	// Fixed sizes from the select field: 2, 8, then 16
	always_comb begin
		unique case (i_instr[`SFSU_FIX_HI:`SFSU_FIX_LO])
			2'h0: fix_count = `SFSU_SH_TWO;
			2'h1: fix_count = `SFSU_SH_EIGHT;
			default: fix_count = `SFSU_SH_SIXTEEN;
		endcase
	end

	// Direction and count for the shifter
	always_comb begin
		count = `SFSU_SH_NONE;
		shift_right = 1'b0;
		shift_arith = 1'b0;
		unique case (op)
			SFSU_OP_DYN_A, SFSU_OP_DYN_L: begin
				count = dyn_count;
				shift_right = amt_neg;
				shift_arith = (op == SFSU_OP_DYN_A);
			end
			SFSU_OP_ASL1, SFSU_OP_LSL1: begin
				count = `SFSU_SH_ONE;
			end
			SFSU_OP_ASR1: begin
				count = `SFSU_SH_ONE;
				shift_right = 1'b1;
				shift_arith = 1'b1;
			end
			SFSU_OP_LSR1: begin
				count = `SFSU_SH_ONE;
				shift_right = 1'b1;
			end
			SFSU_OP_LSLN: begin
				count = fix_count;
			end
			SFSU_OP_LSRN: begin
				count = fix_count;
				shift_right = 1'b1;
			end
			// Flag-only words and idle cycles leave the shifter at rest
			default: count = `SFSU_SH_NONE;
		endcase
	end

	// One shared shifter serves every form, the full-width right shift included
	sfsu_barrel u_barrel (
		.i_value(i_dest_reg),
		.i_count(count),
		.i_right(shift_right),
		.i_arith(shift_arith),
		.o_result(shifted)
	);

	// Next-state for write-back
	always_comb begin
		// Index and data hold between writes; only the strobe drops
		nxt_wr_en = 1'b0;
		nxt_wr_idx = wr_idx_ff;
		nxt_wr_data = wr_data_ff;
		unique case (op)
			SFSU_OP_NONE, SFSU_OP_CLAMP, SFSU_OP_CARRY: nxt_wr_en = 1'b0;
			default: begin
				nxt_wr_en = 1'b1;
				nxt_wr_idx = i_instr[`SFSU_DEST_HI:`SFSU_DEST_LO];
				nxt_wr_data = shifted;
			end
		endcase
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			wr_en_ff <= 1'b0;
			wr_idx_ff <= 4'h0;
			wr_data_ff <= 32'h00000000;
		end else begin
			wr_en_ff <= nxt_wr_en;
			wr_idx_ff <= nxt_wr_idx;
			wr_data_ff <= nxt_wr_data;
		end
	end

	// Next-state for the flags
	always_comb begin
		nxt_carry = carry_ff;
		nxt_clamp = clamp_ff;
		// Hit covers flag-only words too, so decode can retire them
		nxt_hit = (op != SFSU_OP_NONE);
		unique case (op)
			SFSU_OP_CLAMP: nxt_clamp = 1'b1;
			SFSU_OP_CARRY: nxt_carry = 1'b1;
			// One-bit shifts hand the bit that leaves to the carry
			SFSU_OP_ASL1, SFSU_OP_LSL1: nxt_carry = i_dest_reg[`SFSU_MSB];
			SFSU_OP_ASR1, SFSU_OP_LSR1: nxt_carry = i_dest_reg[`SFSU_LSB];
			// Multi-bit and dynamic shifts keep the carry
			default: nxt_carry = carry_ff;
		endcase
	end

	// Carry and clamp survive idle cycles; only reset clears clamp, carry also takes the one-bit shift bit; hit drops on an idle cycle
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			carry_ff <= `SFSU_CARRY_RST;
			clamp_ff <= `SFSU_CLAMP_RST;
			hit_ff <= 1'b0;
		end else begin
			carry_ff <= nxt_carry;
			clamp_ff <= nxt_clamp;
			hit_ff <= nxt_hit;
		end
	end

	assign o_wr_en = wr_en_ff;
	assign o_wr_idx = wr_idx_ff;
	assign o_wr_data = wr_data_ff;
	assign o_carry = carry_ff;
	assign o_clamp = clamp_ff;
	assign o_hit = hit_ff;

endmodule // sfsu_core

`default_nettype wire

// ===== bench/sfsu_core_props.sv
`timescale 1ns/1ps
`default_nettype none
module sfsu_core_props (
	input wire logic i_clk_sys, i_rst_n, i_valid,
	input wire logic [15:0] i_instr,
	input wire logic [31:0] i_dest_reg, i_amount_reg,
	input wire logic o_wr_en, o_carry, o_clamp, o_hit,
	input wire logic [3:0] o_wr_idx,
	input wire logic [31:0] o_wr_data
);
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_n);
	logic [31:0] d_ff, a_ff, sar;
	logic [15:0] op, dyn;
	always_ff @(posedge i_clk_sys) begin
		d_ff <= i_dest_reg;
		a_ff <= i_amount_reg;
	end
	assign op = i_valid ? (i_instr & 16'hf0ff) : 16'h0000;
	assign dyn = i_valid ? (i_instr & 16'hf00f) : 16'h0000;
	// Separate net keeps the shift signed; a ternary would make it logical
	assign sar = $signed(d_ff) >>> (6'd32 - a_ff[4:0]);
	a_clamp_set: assert property (i_valid && i_instr == 16'h0058
		|=> o_clamp && !o_wr_en && o_hit && $stable(o_carry)) else $error("clamp set");
	a_carry_set: assert property (i_valid && i_instr == 16'h0018
		|=> o_carry && !o_wr_en && $stable(o_clamp)) else $error("carry set");
	a_arith_left: assert property (op == 16'h4020 |=> o_wr_data == d_ff << 1 && o_carry == d_ff[31]) else $error("asl");
	a_arith_right: assert property (op == 16'h4021 |=> o_wr_en && o_wr_data == {d_ff[31], d_ff[31:1]}
		&& o_carry == d_ff[0] && o_wr_idx == $past(i_instr[11:8])) else $error("asr");
	a_logic_left: assert property (op == 16'h4000 |=> o_wr_data == d_ff << 1 && o_carry == d_ff[31]) else $error("lsl");
	a_logic_right: assert property (op == 16'h4001 |=> o_wr_data == d_ff >> 1 && o_carry == d_ff[0]) else $error("lsr");
	a_left_two: assert property (op == 16'h4008 |=> o_wr_data == d_ff << 2 && $stable(o_carry)) else $error("lsl2");
	a_right_sixteen: assert property (op == 16'h4029 |=> o_wr_data == d_ff >> 16 && $stable(o_carry)) else $error("lsr16");
	a_dyn_arith: assert property (dyn == 16'h400c |=> $stable(o_carry)
		&& o_wr_data == (a_ff[31] ? sar : d_ff << a_ff[4:0])) else $error("dyn arith");
	a_dyn_logic: assert property (dyn == 16'h400d |=> $stable(o_carry)
		&& o_wr_data == (a_ff[31] ? d_ff >> (6'd32 - a_ff[4:0]) : d_ff << a_ff[4:0])) else $error("dyn logic");
	a_idle_quiet: assert property (!i_valid |=> !o_hit && !o_wr_en) else $error("idle output");
endmodule // sfsu_core_props
bind sfsu_core sfsu_core_props u_sfsu_core_props(.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_valid(i_valid),
	.i_instr(i_instr), .i_dest_reg(i_dest_reg), .i_amount_reg(i_amount_reg), .o_wr_en(o_wr_en),
	.o_carry(o_carry), .o_clamp(o_clamp), .o_hit(o_hit), .o_wr_idx(o_wr_idx), .o_wr_data(o_wr_data));
`default_nettype wire

// ===== bench/sfsu_regfile.sv
`timescale 1ns/1ps
`default_nettype none
module sfsu_regfile (
	input wire logic i_clk_sys,
	input wire logic [15:0] i_instr,
	input wire logic i_wr_en,
	input wire logic [3:0] i_wr_idx,
	input wire logic [31:0] i_wr_data,
	output logic [31:0] o_dest_reg,
	output logic [31:0] o_amount_reg
);
	logic [31:0] rf [16];
	assign o_dest_reg = rf[i_instr[11:8]];
	assign o_amount_reg = rf[i_instr[7:4]];
	// Plain always so the bench may preload entries
	always @(posedge i_clk_sys) if (i_wr_en) rf[i_wr_idx] <= i_wr_data;
endmodule // sfsu_regfile
`default_nettype wire

// ===== bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic i_clk_sys, i_rst_n, i_valid, o_wr_en, o_carry, o_clamp, o_hit;
	logic [15:0] i_instr;
	logic [31:0] i_dest_reg, i_amount_reg, o_wr_data;
	logic [3:0] o_wr_idx;
	int num_errors = 0;
	int cmp_count = 0;
	sfsu_core u_sfsu_core(.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_valid(i_valid), .i_instr(i_instr),
		.i_dest_reg(i_dest_reg), .i_amount_reg(i_amount_reg), .o_wr_en(o_wr_en), .o_wr_idx(o_wr_idx),
		.o_wr_data(o_wr_data), .o_carry(o_carry), .o_clamp(o_clamp), .o_hit(o_hit));
	sfsu_regfile u_sfsu_regfile(.i_clk_sys(i_clk_sys), .i_instr(i_instr), .i_wr_en(o_wr_en), .i_wr_idx(o_wr_idx),
		.i_wr_data(o_wr_data), .o_dest_reg(i_dest_reg), .o_amount_reg(i_amount_reg));
	initial begin
		i_clk_sys = 1'b0;
		forever #50 i_clk_sys = ~i_clk_sys;
	end
	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask
	// Gap cycle lets the previous write-back land before preloading
	task issue(input logic [15:0] w, input logic [31:0] dv, av, ed, input logic ew, ec, eh);
		@(posedge i_clk_sys);
		i_valid <= 1'b1;
		i_instr <= w;
		#1 u_sfsu_regfile.rf[w[7:4]] = av;
		u_sfsu_regfile.rf[w[11:8]] = dv;
		@(posedge i_clk_sys);
		i_valid <= 1'b0;
		#1 chk("wr_en", o_wr_en, ew);
		if (ew) chk("data", o_wr_data, ed);
		if (ew) chk("idx", o_wr_idx, w[11:8]);
		chk("carry", o_carry, ec);
		chk("hit", o_hit, eh);
	endtask
	task t_flags;
		chk("carry", o_carry, 1'b0);
		chk("clamp", o_clamp, 1'b0);
		issue(16'h0018, 0, 0, 0, 0, 1, 1);
		issue(16'h0058, 0, 0, 0, 0, 1, 1);
		chk("clamp", o_clamp, 1'b1);
		issue(16'h4024, 5, 5, 0, 0, 1, 0);
	endtask
	task t_one_bit;
		issue(16'h4121, 32'h80000001, 32'h80000001, 32'hc0000000, 1, 1, 1);
		issue(16'h4320, 32'h80000001, 32'h80000001, 32'h00000002, 1, 1, 1);
		issue(16'h4500, 32'h00000001, 32'h00000001, 32'h00000002, 1, 0, 1);
		issue(16'h4601, 32'h80000001, 32'h80000001, 32'h40000000, 1, 1, 1);
		issue(16'h4701, 32'h00000002, 32'h00000002, 32'h00000001, 1, 0, 1);
	endtask
	task t_fixed;
		logic [15:0] op [6];
		logic [31:0] ex [6];
		op = '{16'h4008, 16'h4018, 16'h4028, 16'h4009, 16'h4019, 16'h4029};
		ex = '{32'h48d159e0, 32'h34567800, 32'h56780000, 32'h048d159e, 32'h00123456, 32'h00001234};
		issue(16'h0018, 0, 0, 0, 0, 1, 1);
		for (int i = 0; i < 6; i++) issue(op[i] | 16'h0200, 32'h12345678, 32'h12345678, ex[i], 1, 1, 1);
	endtask
	task t_dynamic;
		issue(16'h421c, 32'h80180000, 32'hffffffec, 32'hfffff801, 1, 1, 1);
		issue(16'h421c, 32'hfffff801, 32'h00000014, 32'h80100000, 1, 1, 1);
		issue(16'h421d, 32'h80180000, 32'hffffffec, 32'h00000801, 1, 1, 1);
		issue(16'h421d, 32'h80000000, 32'hffffffe0, 32'h00000000, 1, 1, 1);
		issue(16'h421c, 32'h80000000, 32'hffffffe0, 32'hffffffff, 1, 1, 1);
		issue(16'h421d, 32'h89abcdef, 32'h00000000, 32'h89abcdef, 1, 1, 1);
		issue(16'h421c, 32'h00000001, 32'h0000001f, 32'h80000000, 1, 1, 1);
	endtask
	// Mid-run reset must clear flags and write-back, then accept work again
	task t_reset;
		@(posedge i_clk_sys);
		i_rst_n <= 1'b0;
		repeat (2) @(posedge i_clk_sys);
		i_rst_n <= 1'b1;
		#1 chk("carry", o_carry, 1'b0);
		chk("clamp", o_clamp, 1'b0);
		chk("hit", o_hit, 1'b0);
		chk("wr_en", o_wr_en, 1'b0);
		chk("idx", o_wr_idx, 4'h0);
		chk("data", o_wr_data, 32'h00000000);
		issue(16'h0058, 0, 0, 0, 0, 0, 1);
		chk("clamp", o_clamp, 1'b1);
	endtask
	task results;
		$display("errors %0d compares %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial begin
		#50000 num_errors++;
		results;
	end
	initial begin
		i_rst_n = 1'b0;
		i_valid = 1'b0;
		i_instr = 16'h0000;
		repeat (8) @(posedge i_clk_sys);
		i_rst_n <= 1'b1;
		t_flags;
		t_one_bit;
		t_fixed;
		t_dynamic;
		t_reset;
		results;
	end
endmodule // testbench
`default_nettype wire
